// File: flpe_defines.vh
`ifndef FLPE_DEFINES_VH
`define FLPE_DEFINES_VH

// ==========================================================================
// Operation codes
`define FLPE_OPC_ADD       3'h0
`define FLPE_OPC_SUB       3'h1
`define FLPE_OPC_MUL       3'h2
`define FLPE_OPC_DIV       3'h3
`define FLPE_OPC_CVT       3'h4

// ==========================================================================
// Register map
`define FLPE_ADDR_CSR      8'h00
`define FLPE_ADDR_STAT     8'h04
`define FLPE_CSR_RESET     32'h00001F80
`define FLPE_CSR_FLG       5:0
`define FLPE_CSR_MSK       12:7
`define FLPE_STAT_CAUSE    5:0
`define FLPE_STAT_NAN      11:8
`define FLPE_STAT_BUSY     16

// ==========================================================================
// Condition bit positions
`define FLPE_C_INV         0
`define FLPE_C_DZ          1
`define FLPE_C_DEN         2
`define FLPE_C_OVF         3
`define FLPE_C_UNF         4
`define FLPE_C_INX         5
`define FLPE_C_PRE         2:0
`define FLPE_C_POST        5:3

// ==========================================================================
// Formats
`define FLPE_SP_SIGN       31
`define FLPE_SP_EXP        30:23
`define FLPE_SP_FRAC       22:0
`define FLPE_SP_QBIT       22
`define FLPE_SP_WORD       31:0
`define FLPE_DP_SIGN       63
`define FLPE_DP_EXP        62:52
`define FLPE_DP_FRAC       51:0
`define FLPE_DP_QBIT       51
`define FLPE_SP_EXP_ONES   8'hFF
`define FLPE_DP_EXP_ONES   11'h7FF
`define FLPE_SP_QUIET      32'h00400000
`define FLPE_DP_QUIET      64'h0008000000000000
`define FLPE_SP_DEF_NAN    32'hFFC00000
`define FLPE_DP_DEF_NAN    64'hFFF8000000000000
`define FLPE_INT_INDEF     32'h80000000

// ==========================================================================
// Reset value of the mask field: every condition masked
`define FLPE_MSK_RESET     6'h3F

`endif

// File: flpe_lane.v
`timescale 1ns/1ps
`include "flpe_defines.vh"

// ==========================================================================
// One lane: operand classes, pre-computation conditions, NaN result
module flpe_lane (
  // Lane format and operands
  input  wire        dbl,
  input  wire [2:0]  opc,
  input  wire [63:0] src_a,
  input  wire [63:0] src_b,
  // Pre-computation conditions
  output wire        inv,
  output wire        dz,
  output wire        den,
  // NaN or indefinite result that replaces the arithmetic
  output wire        nan_hit,
  output reg  [63:0] nan_val
);

  // Class bits: {nan, signaling_nan, inf, zero, denormal, sign}
  function [5:0] classify;
    input        d;
    input [63:0] x;
    reg          ones;
    reg          zexp;
    reg          fnz;
    reg          qb;
    reg          sg;
    begin
      ones = d ? (x[`FLPE_DP_EXP] == `FLPE_DP_EXP_ONES)
               : (x[`FLPE_SP_EXP] == `FLPE_SP_EXP_ONES);
      zexp = d ? (x[`FLPE_DP_EXP] == 11'h000) : (x[`FLPE_SP_EXP] == 8'h00);
      fnz  = d ? (x[`FLPE_DP_FRAC] != 52'h0) : (x[`FLPE_SP_FRAC] != 23'h0);
      qb   = d ? x[`FLPE_DP_QBIT] : x[`FLPE_SP_QBIT];
      sg   = d ? x[`FLPE_DP_SIGN] : x[`FLPE_SP_SIGN];
      classify = {ones & fnz, ones & fnz & ~qb, ones & ~fnz,
                  zexp & ~fnz, zexp & fnz, sg};
    end
  endfunction

  wire [5:0] ca = classify(dbl, src_a);
  wire [5:0] cb = classify(dbl, src_b);
  wire       cvt = (opc == `FLPE_OPC_CVT);
  wire       b_nan  = cb[5] & ~cvt;
  wire       b_signaling_nan = cb[4] & ~cvt;

  // Invalid arithmetic without NaN operands
  wire eff_sub = ((opc == `FLPE_OPC_ADD) & (ca[0] ^ cb[0])) |
                 ((opc == `FLPE_OPC_SUB) & ~(ca[0] ^ cb[0]));
  wire ar_inv  = ~ca[5] & ~b_nan &
                 ((eff_sub & ca[3] & cb[3]) |
                  ((opc == `FLPE_OPC_MUL) & ((ca[3] & cb[2]) | (ca[2] & cb[3]))) |
                  ((opc == `FLPE_OPC_DIV) & ((ca[3] & cb[3]) | (ca[2] & cb[2]))));

  // Outside conversion, quiet NaNs alone stay quiet; signaling NaNs and invalid arithmetic do not
  assign inv     = cvt ? ca[5] : (ca[4] | b_signaling_nan | ar_inv);
  assign nan_hit = ca[5] | b_nan | ar_inv;
  // NaN result outranks the non-invalid conditions
  assign dz      = ~nan_hit & (opc == `FLPE_OPC_DIV) & cb[2] &
                   ~ca[2] & ~ca[3];
  assign den     = ~nan_hit & (ca[1] | (cb[1] & ~cvt));

  always @*
  begin
    nan_val = 64'h0;
    if (cvt)
      nan_val[`FLPE_SP_WORD] = `FLPE_INT_INDEF;
    else if (ca[4])
      nan_val = dbl ? (src_a | `FLPE_DP_QUIET)
                    : {32'h0, src_a[`FLPE_SP_WORD] | `FLPE_SP_QUIET};
    else if (ca[5])
      nan_val = src_a;
    else if (b_signaling_nan)
      nan_val = dbl ? (src_b | `FLPE_DP_QUIET)
                    : {32'h0, src_b[`FLPE_SP_WORD] | `FLPE_SP_QUIET};
    else if (b_nan)
      nan_val = src_b;
    else if (ar_inv)
      nan_val = dbl ? `FLPE_DP_DEF_NAN : {32'h0, `FLPE_SP_DEF_NAN};
  end

endmodule

// File: flpe_top.v
// Contract
// - Detect six conditions separately: invalid, zero-divide, denormal, overflow, underflow, inexact.
// - Invalid, zero-divide, denormal checked before arithmetic; unmasked one leaves destination.
// - Overflow, underflow, inexact checked only after the arithmetic result exists.
// - Each condition has its own mask bit in the control/status register.
// - Masked conditions only: hardware makes the default result and completes.
// - Unmasked condition: no result written, exception signalled instead.
// - Quiet NaNs do not raise invalid (conversion of a quiet NaN raises it here); NaN result outranks other conditions.
// - Single default NaN: sign set, exponent ones, top fraction bit only.
// - Double default NaN: sign set, exponent ones, top fraction bit only.
// - Failed conversion to 32-bit integer returns only-top-bit-set indefinite value.
// - NaN cases raise invalid unless non-exception; then masked equals unmasked.
// - Signaling NaN first or alone gives it quieted; quiet first wins over signaling.
// - Two quiet NaNs return the first unchanged, no exception.
// - Quiet NaN with real value returns that quiet NaN, no exception.
// - Invalid arithmetic without signaling NaN returns precision's default NaN.
// - Packed flags are the OR of all lane flags.
`timescale 1ns/1ps
`include "flpe_defines.vh"

module flpe_top (
  // Clock and reset
  input  wire         CLK,
  input  wire         RST,
  // APB slave
  input  wire         PSEL,
  input  wire         PENABLE,
  input  wire         PWRITE,
  input  wire [7:0]   PADDR,
  input  wire [31:0]  PWDATA,
  output reg  [31:0]  PRDATA,
  output wire         PREADY,
  output wire         PSLVERR,
  // Operation issue from the pipeline
  input  wire         OP_VALID,
  output wire         OP_READY,
  input  wire [2:0]   OP_CODE,
  input  wire         OP_DOUBLE,
  input  wire         OP_PACKED,
  input  wire [127:0] OP_SRC_A,
  input  wire [127:0] OP_SRC_B,
  // Arithmetic unit request
  output wire         ARITH_REQ,
  output reg  [2:0]   ARITH_CODE,
  output reg          ARITH_DOUBLE,
  output reg  [3:0]   ARITH_LANES,
  output reg  [127:0] ARITH_SRC_A,
  output reg  [127:0] ARITH_SRC_B,
  // Arithmetic unit answer
  input  wire         ARITH_DONE,
  input  wire [127:0] ARITH_RESULT,
  input  wire [3:0]   ARITH_OVF,
  input  wire [3:0]   ARITH_UNF,
  input  wire [3:0]   ARITH_INX,
  input  wire [3:0]   ARITH_CVT_INV,
  // Completion towards the pipeline
  output reg          RES_VALID,
  output reg  [127:0] RES_DATA,
  output reg          EXC_FAULT,
  output reg          EXC_TRAP,
  output reg  [5:0]   EXC_CAUSE
);

  // ========================================================================
  // State
  reg         state_q;
  reg         state_d;
  reg  [5:0]  flags_q;
  reg  [5:0]  flags_d;
  reg  [5:0]  masks_q;
  reg  [2:0]  pre_q;
  reg  [3:0]  nan_lanes_q;
  reg  [5:0]  set_now;
  reg  [31:0] csr_view;
  reg  [31:0] stat_view;

  // Sequencer states
  localparam  ST_IDLE  = 1'h0;
  localparam  ST_ARITH = 1'h1;

  wire        accept = OP_VALID & OP_READY;
  wire        finish = (state_q == ST_ARITH) & ARITH_DONE;

  assign OP_READY  = (state_q == ST_IDLE);
  assign ARITH_REQ = (state_q == ST_ARITH);

  // ========================================================================
  // Active lanes
  wire [3:0] act_now = ~OP_PACKED ? 4'h1 : (OP_DOUBLE ? 4'h3 : 4'hF);

  // ========================================================================
  // Per-lane classification and result merge
  wire [3:0]   l_inv;
  wire [3:0]   l_dz;
  wire [3:0]   l_den;
  wire [3:0]   l_nan;
  wire [3:0]   q_nan;
  wire [127:0] fin_sgl;
  wire [127:0] fin_dbl;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_lane
      wire [63:0] la;
      wire [63:0] lb;
      wire [63:0] nv;
      wire [63:0] slot;
      wire        cvt_bad;
      reg  [63:0] nv_q;
      reg         nan_q;

      if (i < 2)
      begin : g_wide
        assign la = OP_DOUBLE ? OP_SRC_A[64*i +: 64] : {32'h0, OP_SRC_A[32*i +: 32]};
        assign lb = OP_DOUBLE ? OP_SRC_B[64*i +: 64] : {32'h0, OP_SRC_B[32*i +: 32]};
      end
      else
      begin : g_narrow
        assign la = {32'h0, OP_SRC_A[32*i +: 32]};
        assign lb = {32'h0, OP_SRC_B[32*i +: 32]};
      end

      flpe_lane u_lane (
        .dbl     (OP_DOUBLE),
        .opc     (OP_CODE),
        .src_a   (la),
        .src_b   (lb),
        .inv     (l_inv[i]),
        .dz      (l_dz[i]),
        .den     (l_den[i]),
        .nan_hit (l_nan[i]),
        .nan_val (nv)
      );

      always @(posedge CLK or posedge RST)
      begin
        if (RST)
        begin
          nv_q  <= 64'h0;
          nan_q <= 1'b0;
        end
        else if (accept)
        begin
          nv_q  <= nv;
          nan_q <= l_nan[i] & act_now[i];
        end
      end

      assign q_nan[i] = nan_q;
      // Out-of-range conversion reported by the arithmetic unit
      assign cvt_bad  = ARITH_CVT_INV[i] & ARITH_LANES[i] & ~nan_q &
                        (ARITH_CODE == `FLPE_OPC_CVT);
      // NaN override wins over whatever the arithmetic computed
      assign slot = nan_q   ? nv_q :
                    cvt_bad ? {32'h0, `FLPE_INT_INDEF} :
                    (ARITH_DOUBLE ? ARITH_RESULT[64*(i%2) +: 64]
                                  : {32'h0, ARITH_RESULT[32*i +: 32]});

      assign fin_sgl[32*i +: 32] = slot[`FLPE_SP_WORD];
      if (i < 2)
      begin : g_dslot
        assign fin_dbl[64*i +: 64] = slot;
      end
    end
  endgenerate

  // ========================================================================
  // Pre-computation decision on issue
  wire [2:0] pre_now;
  assign pre_now[`FLPE_C_INV] = |(l_inv & act_now);
  assign pre_now[`FLPE_C_DZ]  = |(l_dz  & act_now);
  assign pre_now[`FLPE_C_DEN] = |(l_den & act_now);
  wire       pre_fault = |(pre_now & ~masks_q[`FLPE_C_PRE]);

  // ========================================================================
  // Post-computation decision on arithmetic completion
  wire [3:0] post_lanes = ARITH_LANES & ~q_nan;
  wire [3:0] cvt_lanes  = ARITH_CVT_INV & post_lanes &
                          {4{ARITH_CODE == `FLPE_OPC_CVT}};
  wire [5:0] post_all;
  assign post_all[`FLPE_C_INV] = pre_q[`FLPE_C_INV] | (|cvt_lanes);
  assign post_all[`FLPE_C_DZ]  = pre_q[`FLPE_C_DZ];
  assign post_all[`FLPE_C_DEN] = pre_q[`FLPE_C_DEN];
  assign post_all[`FLPE_C_OVF] = |(ARITH_OVF & post_lanes);
  assign post_all[`FLPE_C_UNF] = |(ARITH_UNF & post_lanes);
  assign post_all[`FLPE_C_INX] = |(ARITH_INX & post_lanes);
  wire       post_trap = |(post_all & ~masks_q);

  // ========================================================================
  // Sequencer
  always @*
  begin
    state_d = state_q;
    set_now = 6'h00;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          set_now[`FLPE_C_PRE] = pre_now;
          // Unmasked fault stops here: no arithmetic, no trap checks
          if (!pre_fault)
            state_d = ST_ARITH;
        end
      end
      ST_ARITH:
      begin
        if (ARITH_DONE)
        begin
          set_now = post_all;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q      <= ST_IDLE;
      pre_q        <= 3'h0;
      nan_lanes_q  <= 4'h0;
      ARITH_CODE   <= `FLPE_OPC_ADD;
      ARITH_DOUBLE <= 1'b0;
      ARITH_LANES  <= 4'h0;
      ARITH_SRC_A  <= 128'h0;
      ARITH_SRC_B  <= 128'h0;
    end
    else
    begin
      state_q <= state_d;
      if (accept)
      begin
        pre_q        <= pre_now;
        nan_lanes_q  <= l_nan & act_now;
        ARITH_CODE   <= OP_CODE;
        ARITH_DOUBLE <= OP_DOUBLE;
        ARITH_LANES  <= act_now;
        ARITH_SRC_A  <= OP_SRC_A;
        ARITH_SRC_B  <= OP_SRC_B;
      end
    end
  end

  // ========================================================================
  // Completion outputs
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      RES_VALID <= 1'b0;
      RES_DATA  <= 128'h0;
      EXC_FAULT <= 1'b0;
      EXC_TRAP  <= 1'b0;
      EXC_CAUSE <= 6'h00;
    end
    else
    begin
      RES_VALID <= 1'b0;
      EXC_FAULT <= 1'b0;
      EXC_TRAP  <= 1'b0;
      if (accept && pre_fault)
      begin
        EXC_FAULT <= 1'b1;
        EXC_CAUSE <= {3'h0, pre_now};
      end
      else if (finish)
      begin
        EXC_CAUSE <= post_all;
        if (post_trap)
          EXC_TRAP <= 1'b1;
        else
        begin
          // Data only moves when nothing unmasked fired
          RES_VALID <= 1'b1;
          RES_DATA  <= ARITH_DOUBLE ? fin_dbl : fin_sgl;
        end
      end
    end
  end

  // ========================================================================
  // Control/status register
  wire wr_acc  = PSEL & PENABLE & PWRITE;
  wire hit_csr = (PADDR == `FLPE_ADDR_CSR);
  wire hit_st  = (PADDR == `FLPE_ADDR_STAT);

  // Set wins over a software clear in the same cycle
  always @*
  begin
    flags_d = flags_q;
    if (wr_acc && hit_csr)
      flags_d = PWDATA[`FLPE_CSR_FLG];
    flags_d = flags_d | set_now;
  end

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      flags_q <= 6'h00;
      masks_q <= `FLPE_MSK_RESET;
    end
    else
    begin
      flags_q <= flags_d;
      if (wr_acc && hit_csr)
        masks_q <= PWDATA[`FLPE_CSR_MSK];
    end
  end

  always @*
  begin
    csr_view                 = 32'h0;
    csr_view[`FLPE_CSR_FLG]  = flags_q;
    csr_view[`FLPE_CSR_MSK]  = masks_q;
    stat_view                = 32'h0;
    stat_view[`FLPE_STAT_CAUSE] = EXC_CAUSE;
    stat_view[`FLPE_STAT_NAN]   = nan_lanes_q;
    stat_view[`FLPE_STAT_BUSY]  = state_q;
  end

  // ========================================================================
  // APB answer: zero wait, read data captured in the setup cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_csr & ~hit_st;

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
      PRDATA <= 32'h0;
    else if (PSEL && !PENABLE)
      PRDATA <= hit_csr ? csr_view : (hit_st ? stat_view : 32'h0);
  end

endmodule

// File: flpe_properties.sv
`timescale 1ns/1ps
// ==========
// Checker on the top-level ports
module flpe_properties (
  // Clock and reset
  input wire         CLK,
  input wire         RST,
  // Register bus
  input wire         PSEL,
  input wire         PENABLE,
  input wire [7:0]   PADDR,
  input wire         PREADY,
  input wire         PSLVERR,
  // Issue and arithmetic unit
  input wire         OP_VALID,
  input wire         OP_READY,
  input wire         ARITH_REQ,
  input wire         ARITH_DONE,
  input wire [127:0] ARITH_SRC_A,
  // Completion
  input wire         RES_VALID,
  input wire [127:0] RES_DATA,
  input wire         EXC_FAULT,
  input wire         EXC_TRAP,
  input wire [5:0]   EXC_CAUSE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  sequence take_s;
    OP_VALID && OP_READY;
  endsequence
  sequence done_s;
    ARITH_REQ && ARITH_DONE;
  endsequence

  take_answer_a: assert property (take_s |=> EXC_FAULT || ARITH_REQ)
    else $error("taken op neither faulted nor reached the arithmetic unit");
  fault_after_take_a: assert property (EXC_FAULT |-> $past(OP_VALID && OP_READY))
    else $error("fault not one cycle after the take");
  fault_cause_a: assert property (EXC_FAULT |-> EXC_CAUSE[2:0] != 3'h0)
    else $error("fault without a pre-computation cause");
  fault_quiet_a: assert property (EXC_FAULT |-> !ARITH_REQ && !RES_VALID && !EXC_TRAP)
    else $error("fault did not suppress the computation");
  res_after_done_a: assert property (RES_VALID |-> $past(ARITH_DONE && ARITH_REQ))
    else $error("result without an arithmetic completion");
  done_answer_a: assert property (done_s |=> (RES_VALID ^ EXC_TRAP) && !ARITH_REQ)
    else $error("completion gave no single answer");
  trap_no_write_a: assert property (EXC_TRAP |-> $stable(RES_DATA) && (EXC_CAUSE & 6'h39) != 6'h00)
    else $error("trap wrote a result or lacks a late cause");
  req_hold_a: assert property (ARITH_REQ && !ARITH_DONE |=> ARITH_REQ && $stable(ARITH_SRC_A))
    else $error("arithmetic request dropped or changed");
  bus_error_a: assert property (PSEL && PENABLE && PADDR != 8'h00 && PADDR != 8'h04 |-> PSLVERR && PREADY)
    else $error("unmapped access not flagged");
endmodule

bind flpe_top flpe_properties u_props (.CLK, .RST, .PSEL, .PENABLE, .PADDR, .PREADY, .PSLVERR,
  .OP_VALID, .OP_READY, .ARITH_REQ, .ARITH_DONE, .ARITH_SRC_A, .RES_VALID, .RES_DATA,
  .EXC_FAULT, .EXC_TRAP, .EXC_CAUSE);

// File: flpe_arith_model.sv
`timescale 1ns/1ps
// ==========
// Arithmetic unit standing behind the block
module flpe_arith_model (
  // Clock and reset
  input  wire         CLK,
  input  wire         RST,
  // Request from the block, set-up from the bench
  input  wire         req,
  input  wire [3:0]   lat,
  input  wire [127:0] val,
  input  wire [15:0]  flg,
  // Answer
  output wire         done,
  output wire [127:0] result,
  output wire [15:0]  flg_o
);
  reg [3:0] cnt_q;

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
      cnt_q <= 4'h0;
    else
      cnt_q <= (req && !done) ? cnt_q + 4'h1 : 4'h0;
  end

  assign done = req && (cnt_q == lat);
  // Outside the done cycle the answer is garbage, so nothing may lean on it
  assign result = done ? val : ~val;
  assign flg_o = done ? flg : ~flg;
endmodule

// File: simd_fp_nan_exception_response_tb_top.sv
`timescale 1ns/1ps
module simd_fp_nan_exception_response_tb_top;
  // ==========
  // Stimulus and observation
  reg          CLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  reg          OP_VALID = 1'h0, OP_DOUBLE = 1'h0, OP_PACKED = 1'h0, er;
  reg  [7:0]   PADDR = 8'h00;
  reg  [31:0]  PWDATA = 32'h0, rd;
  reg  [2:0]   OP_CODE = 3'h0;
  reg  [127:0] OP_SRC_A = 128'h0, OP_SRC_B = 128'h0;
  reg  [3:0]   lat = 4'h0;
  reg  [15:0]  pflg = 16'h0;
  wire [31:0]  PRDATA;
  wire [127:0] ARITH_RESULT, RES_DATA, ARITH_SRC_A, ARITH_SRC_B;
  wire [15:0]  aflg;
  wire [5:0]   EXC_CAUSE;
  wire [3:0]   ARITH_LANES;
  wire [2:0]   ARITH_CODE;
  wire         PREADY, PSLVERR, OP_READY, ARITH_REQ, ARITH_DONE, RES_VALID, EXC_FAULT, EXC_TRAP;
  wire         ARITH_DOUBLE;
  int          fail_count = 0, n_compared = 0, cyc = 0, i;
  localparam [127:0] AV = {4{32'h3F800000}};

  flpe_top u_dut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .OP_VALID, .OP_READY, .OP_CODE, .OP_DOUBLE, .OP_PACKED, .OP_SRC_A, .OP_SRC_B,
    .ARITH_REQ, .ARITH_CODE, .ARITH_DOUBLE, .ARITH_LANES, .ARITH_SRC_A, .ARITH_SRC_B,
    .ARITH_DONE, .ARITH_RESULT, .ARITH_OVF(aflg[3:0]), .ARITH_UNF(aflg[7:4]),
    .ARITH_INX(aflg[11:8]), .ARITH_CVT_INV(aflg[15:12]), .RES_VALID, .RES_DATA, .EXC_FAULT,
    .EXC_TRAP, .EXC_CAUSE);
  flpe_arith_model u_arith (.CLK, .RST, .req(ARITH_REQ), .lat, .val(AV), .flg(pflg),
    .done(ARITH_DONE), .result(ARITH_RESULT), .flg_o(aflg));

  always #12.5 CLK = ~CLK;

  // ==========
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run;
    end
  end

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input [63:0] got, input [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input w, input [7:0] ad, input [31:0] wd);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do @(posedge CLK); while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    // One idle edge, so a following call never drives PSEL twice in a step
    @(posedge CLK);
  endtask

  // ==========
  // One op: program the register, issue, judge the outcome and the flags
  task run(input [4:0] m, input [63:0] a, input [63:0] b, input [15:0] w, input [15:0] pf,
           input [1:0] k, input [63:0] r, input [5:0] f);
    reg [127:0] old;
    int         n;
    apb(1'h1, 8'h00, {16'h0, w});
    old = RES_DATA;
    {OP_CODE, OP_DOUBLE, OP_PACKED} <= m;
    OP_SRC_A <= {a, a};
    OP_SRC_B <= {b, b};
    pflg <= pf;
    lat <= lat + 4'h1;
    OP_VALID <= 1'h1;
    do @(posedge CLK); while (OP_READY !== 1'h1);
    OP_VALID <= 1'h0;
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while ((RES_VALID | EXC_FAULT | EXC_TRAP) !== 1'h1 && n < 100);
    chk({61'h0, RES_VALID, EXC_TRAP, EXC_FAULT}, {61'h0, k == 2'h0, k});
    chk({58'h0, EXC_CAUSE}, {58'h0, f});
    // A refused op must leave the old destination in place
    chk(RES_DATA[63:0], k != 2'h0 ? old[63:0] : r);
    // Operands and lane set go to the arithmetic side as issued
    chk({56'h0, ARITH_CODE, ARITH_DOUBLE, ARITH_LANES},
        {56'h0, m[4:1], m[0] ? (m[1] ? 4'h3 : 4'hF) : 4'h1});
    chk(ARITH_SRC_A[127:64], a);
    chk(ARITH_SRC_B[63:0], b);
    @(posedge CLK);
    apb(1'h0, 8'h00, 32'h0);
    chk({32'h0, rd}, {48'h0, w | {10'h0, f}});
    apb(1'h0, 8'h04, 32'h0);
    chk({32'h0, rd & 32'h0001003F}, {58'h0, f});
  endtask

  initial
  begin
    repeat (20) @(posedge CLK);
    RST <= 1'h0;
    @(posedge CLK);
    apb(1'h0, 8'h00, 32'h0);
    chk({32'h0, rd}, 64'h1F80);
    apb(1'h0, 8'h08, 32'h0);
    chk({31'h0, er, rd}, 64'h100000000);
    for (i = 0; i < 4; i++)
      run({i[2:0], 2'h0}, 64'h7F800001, 64'h7FC00005, 16'h1F80, 16'h0, 2'h0,
          64'h3F8000007FC00001, 6'h01);
    run(5'h00,64'h7FC00003,64'h7F800001,16'h1F80,16'h0,2'h0,64'h3F8000007FC00003,6'h01);
    run(5'h00,64'hFFC00007,64'h7FC00005,16'h1F00,16'h0,2'h0,
        64'h3F800000FFC00007,6'h00);
    run(5'h00,64'h40000000,64'h7FC00009,16'h1F01,16'h0,2'h0,
        64'h3F8000007FC00009,6'h00);
    run(5'h04,64'h7F800000,64'h7F800000,16'h1F80,16'h0,2'h0,
        64'h3F800000FFC00000,6'h01);
    run(5'h0A, 64'h7FF0000000000000, 64'h0, 16'h1F80, 16'h0, 2'h0,
        64'hFFF8000000000000, 6'h01);
    run(5'h02, 64'h7FF0000000000001, 64'h3FF0000000000000, 16'h1F80, 16'h0, 2'h0,
        64'h7FF8000000000001, 6'h01);
    run(5'h12,64'h7FF8000000000000,64'h0,16'h1F80,16'h0,2'h0,64'h80000000,6'h01);
    run(5'h12,64'h3FF0000000000000,64'h0,16'h1F80,16'h1000,2'h0,64'h80000000,6'h01);
    run(5'h00,64'h7F800001,64'h3F800000,16'h1F00,16'h0001,2'h1,64'h0,6'h01);
    run(5'h0C,64'h3F800000,64'h00000000,16'h1E80,16'h0,2'h1,64'h0,6'h02);
    run(5'h0C,64'h7FC00011,64'h00000000,16'h1E80,16'h0,2'h0,64'h3F8000007FC00011,6'h00);
    run(5'h00,64'h00000001,64'h3F800000,16'h1D80,16'h0,2'h1,64'h0,6'h04);
    run(5'h00,64'h3F800000,64'h3F800000,16'h1F80,16'h0001,2'h0,AV[63:0],6'h08);
    run(5'h00,64'h3F800000,64'h3F800000,16'h1B80,16'h0001,2'h2,64'h0,6'h08);
    run(5'h00,64'h3F800000,64'h3F800000,16'h1780,16'h0010,2'h2,64'h0,6'h10);
    run(5'h00,64'h3F800000,64'h3F800000,16'h1F80,16'h0100,2'h0,AV[63:0],6'h20);
    run(5'h01,64'h3F800000,64'h3F800000,16'h1F80,16'h0004,2'h0,AV[63:0],6'h08);
    complete_run;
  end
endmodule
